// *** rtl/tsfde_core.sv ***
// Fetch/decode/execute pipeline control with shared bus master.
// Assumes a memory that answers one access per bus cycle via rdy_i.
`timescale 1ns/1ns
module tsfde_core
  import tsfde_pkg::*;
#(
  parameter int NREG = 16
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        clken_i,
  input  wire logic        rdy_i,
  input  wire logic        cmp_mode_i,
  input  wire logic [31:0] rdata_i,
  output logic      [31:0] addr_o,
  output logic      [31:0] wdata_o,
  output logic             write_o,
  output logic      [1:0]  size_o,
  output logic      [1:0]  cyc_o,
  output logic      [31:0] pc_o
);

  // ==========================================================
  // Pipeline registers
  logic [31:0] pc_reg;
  logic [31:0] dec_ir_reg;
  logic        dec_v_reg;
  logic [31:0] ex_ir_reg;
  logic        ex_v_reg;
  logic [31:0] rf_reg [NREG];
  tsfde_ex_t   ex_reg;
  logic [31:0] wide_w;
  logic        adv_w;
  logic        is_mem_w;
  logic        is_br_w;
  logic        is_swp_w;
  logic [31:0] op_a_w;
  logic [31:0] op_b_w;
  logic [31:0] alu_w;
  logic [31:0] maddr_w;
  logic [1:0]  msize_w;

  function automatic logic [31:0] tsfde_align(input logic [31:0] a, input logic [1:0] sz);
    tsfde_align = a;
    if (sz == TSFDE_SZ_WORD) begin
      tsfde_align[1:0] = 2'h0;
    end else if (sz == TSFDE_SZ_HALF) begin
      tsfde_align[0] = 1'b0;
    end
  endfunction : tsfde_align

  // ==========================================================
  // Decode: expansion in the same cycle
  tsfde_expand u_expand (
    .cmp_i  (pc_reg[1] ? rdata_i[31:16] : rdata_i[15:0]),
    .wide_o (wide_w)
  );

  // ==========================================================
  // Execute decode and datapath
  always_comb begin
    is_mem_w = ex_v_reg && (ex_ir_reg[27:26] == 2'h1 ||
               (ex_ir_reg[27:25] == 3'h0 && ex_ir_reg[7] && ex_ir_reg[4]));
    is_swp_w = ex_v_reg && ex_ir_reg[27:23] == 5'h02 && ex_ir_reg[7:4] == 4'h9;
    is_br_w  = ex_v_reg && ex_ir_reg[27:25] == 3'h5;
    op_a_w   = rf_reg[ex_ir_reg[TSFDE_RN_LSB +: 4]];
    op_b_w   = ex_ir_reg[25] ? {24'h0, ex_ir_reg[7:0]}
                             : rf_reg[ex_ir_reg[TSFDE_RM_LSB +: 4]] << ex_ir_reg[11:7];
    case (ex_ir_reg[24:21])
      4'h0:    alu_w = op_a_w & op_b_w;
      4'h1:    alu_w = op_a_w ^ op_b_w;
      4'h2:    alu_w = op_a_w - op_b_w;
      4'hc:    alu_w = op_a_w | op_b_w;
      4'hd:    alu_w = op_b_w;
      default: alu_w = op_a_w + op_b_w;
    endcase
    // Halfword forms split their offset around the type nibble
    if (ex_ir_reg[27:26] == 2'h1) begin
      maddr_w = op_a_w + {20'h0, ex_ir_reg[11:0]};
    end else if (is_swp_w) begin
      maddr_w = op_a_w;
    end else begin
      maddr_w = op_a_w + {24'h0, ex_ir_reg[11:8], ex_ir_reg[3:0]};
    end
    if (ex_ir_reg[27:26] == 2'h1) begin
      msize_w = ex_ir_reg[22] ? TSFDE_SZ_BYTE : TSFDE_SZ_WORD;
    end else if (is_swp_w) begin
      msize_w = ex_ir_reg[22] ? TSFDE_SZ_BYTE : TSFDE_SZ_WORD;
    end else begin
      msize_w = ex_ir_reg[5] ? TSFDE_SZ_HALF : TSFDE_SZ_BYTE;
    end
    adv_w    = clken_i && rdy_i && ex_reg == TSFDE_EX_RUN && !is_mem_w;
  end

  // ==========================================================
  // Fetch stage and program counter
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_reg <= TSFDE_RESET_PC;
      pc_o   <= TSFDE_RESET_PC;
    end else if (adv_w) begin
      if (is_br_w) begin
        pc_reg <= pc_reg + {{6{ex_ir_reg[23]}}, ex_ir_reg[23:0], 2'h0};
        pc_o   <= pc_reg + {{6{ex_ir_reg[23]}}, ex_ir_reg[23:0], 2'h0};
      end else begin
        pc_reg <= pc_reg + (cmp_mode_i ? TSFDE_STEP_CMP : TSFDE_STEP_WIDE);
        pc_o   <= pc_reg + (cmp_mode_i ? TSFDE_STEP_CMP : TSFDE_STEP_WIDE);
      end
    end
  end

  // ==========================================================
  // Decode and execute registers, flush on branch
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dec_ir_reg <= TSFDE_NOP_WORD;
      dec_v_reg  <= 1'b0;
      ex_ir_reg  <= TSFDE_NOP_WORD;
      ex_v_reg   <= 1'b0;
    end else if (clken_i && rdy_i) begin
      if (adv_w) begin
        dec_ir_reg <= cmp_mode_i ? wide_w : rdata_i;
        dec_v_reg  <= !is_br_w;
        ex_ir_reg  <= dec_ir_reg;
        ex_v_reg   <= dec_v_reg && !is_br_w;
      end else if (ex_reg == TSFDE_EX_WAIT) begin
        ex_v_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Executor state: one data cycle for memory instructions
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ex_reg <= TSFDE_EX_RUN;
    end else if (clken_i && rdy_i) begin
      case (ex_reg)
        TSFDE_EX_RUN:  ex_reg <= is_mem_w ? TSFDE_EX_MEM : TSFDE_EX_RUN;
        TSFDE_EX_MEM:  ex_reg <= TSFDE_EX_WAIT;
        TSFDE_EX_WAIT: ex_reg <= TSFDE_EX_RUN;
        default:       ex_reg <= TSFDE_EX_RUN;
      endcase
    end
  end

  // ==========================================================
  // Register bank write back
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < NREG; i++) begin
        rf_reg[i] <= 32'h0000_0000;
      end
    end else if (clken_i && rdy_i) begin
      if (adv_w && ex_v_reg && ex_ir_reg[27:26] == 2'h0 && ex_ir_reg[24:23] != 2'h2) begin
        rf_reg[ex_ir_reg[TSFDE_RD_LSB +: 4]] <= alu_w;
      end else if (ex_reg == TSFDE_EX_MEM && ex_ir_reg[20]) begin
        rf_reg[ex_ir_reg[TSFDE_RD_LSB +: 4]] <= rdata_i;
      end else if (ex_reg == TSFDE_EX_MEM && is_swp_w) begin
        rf_reg[ex_ir_reg[TSFDE_RD_LSB +: 4]] <= rdata_i;
      end
    end
  end

  // ==========================================================
  // Bus outputs, announced one cycle ahead
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_o  <= TSFDE_RESET_PC;
      wdata_o <= 32'h0000_0000;
      write_o <= 1'b0;
      size_o  <= TSFDE_SZ_WORD;
      cyc_o   <= TSFDE_CYC_NSEQ;
    end else if (clken_i && rdy_i) begin
      if (ex_reg == TSFDE_EX_RUN && is_mem_w) begin
        addr_o  <= tsfde_align(maddr_w, msize_w);
        size_o  <= msize_w;
        write_o <= !ex_ir_reg[20] && !is_swp_w;
        wdata_o <= rf_reg[ex_ir_reg[TSFDE_RD_LSB +: 4]];
        cyc_o   <= TSFDE_CYC_NSEQ;
      end else if (ex_reg == TSFDE_EX_MEM) begin
        write_o <= 1'b0;
        cyc_o   <= TSFDE_CYC_IDLE;
      end else if (ex_reg == TSFDE_EX_WAIT) begin
        addr_o  <= pc_reg;
        size_o  <= TSFDE_SZ_WORD;
        cyc_o   <= TSFDE_CYC_NSEQ;
      end else begin
        addr_o  <= tsfde_align(is_br_w ? pc_reg + {{6{ex_ir_reg[23]}}, ex_ir_reg[23:0], 2'h0} :
                   pc_reg + (cmp_mode_i ? TSFDE_STEP_CMP : TSFDE_STEP_WIDE),
                   cmp_mode_i ? TSFDE_SZ_HALF : TSFDE_SZ_WORD);
        size_o  <= cmp_mode_i ? TSFDE_SZ_HALF : TSFDE_SZ_WORD;
        write_o <= 1'b0;
        cyc_o   <= is_br_w ? TSFDE_CYC_NSEQ : TSFDE_CYC_SEQ;
      end
    end
  end

endmodule : tsfde_core

// *** rtl/tsfde_pkg.sv ***
// Package for the three-stage fetch/decode/execute pipeline control.
// Assumes one clock domain and a single shared instruction/data bus.
package tsfde_pkg;

  // ==========================================================
  // Bus cycle classes
  typedef enum logic [1:0] {
    TSFDE_CYC_IDLE = 2'h0,
    TSFDE_CYC_NSEQ = 2'h2,
    TSFDE_CYC_SEQ  = 2'h3,
    TSFDE_CYC_COPR = 2'h1
  } tsfde_cyc_t;

  // ==========================================================
  // Transfer sizes
  localparam logic [1:0] TSFDE_SZ_BYTE = 2'h0;
  localparam logic [1:0] TSFDE_SZ_HALF = 2'h1;
  localparam logic [1:0] TSFDE_SZ_WORD = 2'h2;

  // ==========================================================
  // Reset values and steps
  localparam logic [31:0] TSFDE_RESET_PC  = 32'h0000_0000;
  localparam logic [31:0] TSFDE_STEP_WIDE = 32'h0000_0004;
  localparam logic [31:0] TSFDE_STEP_CMP  = 32'h0000_0002;
  localparam logic [31:0] TSFDE_NOP_WORD  = 32'he1a0_0000;

  // ==========================================================
  // Wide instruction field positions
  localparam int TSFDE_RN_LSB = 16;
  localparam int TSFDE_RD_LSB = 12;
  localparam int TSFDE_RM_LSB = 0;

  // ==========================================================
  // Executor states
  typedef enum logic [2:0] {
    TSFDE_EX_RUN  = 3'h1,
    TSFDE_EX_MEM  = 3'h2,
    TSFDE_EX_WAIT = 3'h4
  } tsfde_ex_t;

endpackage : tsfde_pkg

// *** rtl/tsfde_expand.sv ***
// Expands a 16-bit compressed instruction into its wide equivalent.
// Assumes purely combinational use inside the decode stage.
`timescale 1ns/1ns
module tsfde_expand
  import tsfde_pkg::*;
(
  input  wire logic [15:0] cmp_i,
  output logic      [31:0] wide_o
);

  always_comb begin
    wide_o = TSFDE_NOP_WORD;
    case (cmp_i[15:13])
      3'h0: begin
        // Shift by immediate: MOVS r0, rm, shift #imm, with rd placed in the Rn field
        wide_o = {12'he1b, 1'b0, cmp_i[2:0], 4'h0, cmp_i[10:6], cmp_i[12:11], 1'b0,
                  1'b0, cmp_i[5:3]};
      end
      3'h1: begin
        // Immediate mov/cmp/add/sub on low register
        case (cmp_i[12:11])
          2'h0: wide_o = {16'he3b0, 1'b0, cmp_i[10:8], 4'h0, cmp_i[7:0]};
          2'h1: wide_o = {12'he35, 1'b0, cmp_i[10:8], 4'h0, 4'h0, cmp_i[7:0]};
          2'h2: wide_o = {12'he29, 1'b0, cmp_i[10:8], 1'b0, cmp_i[10:8], 4'h0,
                          cmp_i[7:0]};
          default: wide_o = {12'he25, 1'b0, cmp_i[10:8], 1'b0, cmp_i[10:8], 4'h0,
                             cmp_i[7:0]};
        endcase
      end
      3'h3: begin
        // Load/store word or byte with immediate offset
        wide_o = {8'he5, 1'b1, cmp_i[12], 1'b0, cmp_i[11], 1'b0, cmp_i[5:3], 1'b0,
                  cmp_i[2:0], 5'h00, cmp_i[10:6], 2'h0};
      end
      3'h4: begin
        // Load/store halfword with immediate offset
        wide_o = {8'he1, 3'h6, cmp_i[11], 1'b0, cmp_i[5:3], 1'b0, cmp_i[2:0], 2'h0,
                  cmp_i[10:9], 4'hb, cmp_i[8:6], 1'b0};
      end
      3'h6: begin
        // Conditional branch
        wide_o = {cmp_i[11:8], 4'ha, {16{cmp_i[7]}}, cmp_i[7:0]};
        wide_o[23:0] = {{16{cmp_i[7]}}, cmp_i[7:0]};
      end
      default: wide_o = TSFDE_NOP_WORD;
    endcase
  end

endmodule : tsfde_expand

// *** tb/tsfde_chk.sv ***
// ==========================================
// Bus checker for the three-stage pipeline core.
// Assumes binding to tsfde_core, one clock domain.
`timescale 1ns/1ns
module tsfde_chk
  import tsfde_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        clken_i,
  input wire logic        rdy_i,
  input wire logic        cmp_mode_i,
  input wire logic [31:0] addr_o,
  input wire logic        write_o,
  input wire logic [1:0]  size_o,
  input wire logic [1:0]  cyc_o,
  input wire logic [31:0] pc_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ==========================================
  // Assertions
  a_word_align:
    assert property (cyc_o != 2'h0 && size_o == TSFDE_SZ_WORD |-> addr_o[1:0] == 2'h0)
    else $error("word access unaligned");
  a_half_align:
    assert property (cyc_o != 2'h0 && size_o == TSFDE_SZ_HALF |-> addr_o[0] == 1'b0)
    else $error("halfword access unaligned");
  a_size_legal:
    assert property (cyc_o != 2'h0 |-> size_o != 2'h3)
    else $error("illegal transfer size");
  a_no_copr:
    assert property (cyc_o != TSFDE_CYC_COPR)
    else $error("coprocessor cycle issued");
  a_write_nseq:
    assert property (write_o |-> cyc_o == TSFDE_CYC_NSEQ)
    else $error("write outside nonsequential cycle");
  a_stall_hold:
    assert property (!(rdy_i && clken_i) |=> $stable(addr_o) && $stable(cyc_o) && $stable(pc_o))
    else $error("bus moved while stalled");
  a_seq_step:
    assert property (rdy_i && clken_i && !cmp_mode_i ##1 cyc_o == TSFDE_CYC_SEQ
                     |-> addr_o == $past(addr_o) + 32'h4 || $past(cyc_o) == 2'h0)
    else $error("sequential fetch not plus four");
  a_pc_fetch:
    assert property (cyc_o == TSFDE_CYC_SEQ && !cmp_mode_i |-> pc_o == addr_o)
    else $error("pc differs from fetch address");
  c_write: cover property (write_o && rdy_i);
  c_stall: cover property (!rdy_i && cyc_o == TSFDE_CYC_SEQ);
  c_nseq: cover property (cyc_o == TSFDE_CYC_NSEQ && addr_o == 32'h20);
endmodule : tsfde_chk

bind tsfde_core tsfde_chk tsfde_chk_i (.clk_i, .arst_n_i, .clken_i, .rdy_i, .cmp_mode_i,
  .addr_o, .write_o, .size_o, .cyc_o, .pc_o);

// *** tb/tsfde_mem.sv ***
// ==========================================
// Memory model on the shared instruction/data bus.
// Assumes 64 words, optional wait state every other cycle.
`timescale 1ns/1ns
module tsfde_mem
  import tsfde_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        clken_i,
  input  wire logic        slow_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        write_i,
  input  wire logic [1:0]  size_i,
  input  wire logic [1:0]  cyc_i,
  output logic             rdy_o,
  output logic      [31:0] rdata_o
);
  logic [31:0] mem [0:63];
  logic [31:0] last_reg = 32'h0;
  logic        wait_reg = 1'b0;
  initial begin
    for (int k = 0; k < 64; k++) mem[k] = TSFDE_NOP_WORD;
  end
  assign rdy_o = !slow_i || wait_reg;
  // Released data bus shows a changing pattern
  assign rdata_o = (rdy_o && cyc_i != 2'h0 && !write_i) ? mem[addr_i[7:2]] : ~last_reg;
  always @(posedge clk_i) begin
    wait_reg <= slow_i && !wait_reg;
    last_reg <= rdata_o;
    if (clken_i && rdy_o && write_i && cyc_i != 2'h0) begin
      for (int b = 0; b < 4; b++) begin
        if (size_i == TSFDE_SZ_WORD || (size_i == TSFDE_SZ_HALF && b[1] == addr_i[1])
            || b[1:0] == addr_i[1:0]) begin
          mem[addr_i[7:2]][8*b +: 8] <= wdata_i[8*b +: 8];
        end
      end
    end
  end
endmodule : tsfde_mem

// *** tb/three_stage_fetch_decode_execute_tb.sv ***
// ==========================================
// Self-checking bench for the pipeline core.
// Assumes tsfde_core, tsfde_mem and the bound checker.
`timescale 1ns/1ns
module three_stage_fetch_decode_execute_tb;
  import tsfde_pkg::*;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        clken_i = 1'b1;
  logic        cmp_mode_i = 1'b0;
  logic        slow = 1'b0;
  logic        rdy_i, write_o;
  logic [31:0] rdata_i, addr_o, wdata_o, pc_o, a0;
  logic [1:0]  size_o, cyc_o;
  int          err_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  tsfde_core tsfde_core_i (.clk_i, .arst_n_i, .clken_i, .rdy_i, .cmp_mode_i, .rdata_i,
    .addr_o, .wdata_o, .write_o, .size_o, .cyc_o, .pc_o);
  tsfde_mem tsfde_mem_i (.clk_i, .clken_i, .slow_i(slow), .addr_i(addr_o), .wdata_i(wdata_o),
    .write_i(write_o), .size_i(size_o), .cyc_i(cyc_o), .rdy_o(rdy_i), .rdata_o(rdata_i));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      final_report();
    end
  end
  // ==========================================
  // Shared tasks
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic restart(input logic cm);
    @(negedge clk_i);
    arst_n_i = 1'b0;
    cmp_mode_i = cm;
    repeat (2) @(negedge clk_i);
    check(addr_o === 32'h0 && pc_o === TSFDE_RESET_PC && cyc_o === 2'h2 && !write_o, "reset");
    arst_n_i = 1'b1;
  endtask : restart
  task automatic final_report();
    $display("Counts: %0d errors, %0d compared", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  // ==========================================
  // Scenarios
  task automatic t_walk();
    for (int k = 0; k < 6 && cyc_o !== TSFDE_CYC_SEQ; k++) @(negedge clk_i);
    a0 = addr_o;
    check(a0 === 32'h4, "first sequential fetch");
    for (int k = 1; k < 4; k++) begin
      @(negedge clk_i);
      check(cyc_o === TSFDE_CYC_SEQ && addr_o === a0 + 32'(4 * k), "fetch step");
    end
  endtask : t_walk
  task automatic t_stall();
    slow = 1'b1;
    repeat (4) begin
      @(negedge clk_i);
      a0 = addr_o;
      if (rdy_i === 1'b0) begin
        @(negedge clk_i);
        check(addr_o === a0, "stall moved bus");
      end
    end
    slow = 1'b0;
    clken_i = 1'b0;
    a0 = pc_o;
    repeat (2) @(negedge clk_i);
    check(pc_o === a0, "clock enable low moved pc");
    clken_i = 1'b1;
  endtask : t_stall
  task automatic t_data(input logic [31:0] op, input logic wr, input logic [1:0] sz);
    tsfde_mem_i.mem[0] = 32'he3a0_0040;
    tsfde_mem_i.mem[1] = op;
    restart(1'b0);
    for (int k = 0; k < 10 && !(cyc_o === TSFDE_CYC_NSEQ && addr_o === 32'h40); k++) begin
      @(negedge clk_i);
    end
    check(write_o === wr && size_o === sz && addr_o === 32'h40, "data cycle");
    check(!wr || wdata_o === 32'h40, "store data");
    @(negedge clk_i);
    check(cyc_o === TSFDE_CYC_IDLE, "idle after data");
    @(negedge clk_i);
    check(cyc_o === TSFDE_CYC_NSEQ && !write_o, "refetch");
  endtask : t_data
  task automatic t_branch();
    tsfde_mem_i.mem[0] = TSFDE_NOP_WORD;
    tsfde_mem_i.mem[1] = TSFDE_NOP_WORD;
    tsfde_mem_i.mem[2] = 32'hea00_0004;
    restart(1'b0);
    for (int k = 0; k < 10 && !(cyc_o === TSFDE_CYC_NSEQ && addr_o === 32'h20); k++) begin
      @(negedge clk_i);
    end
    check(cyc_o === TSFDE_CYC_NSEQ && addr_o === 32'h20, "branch refetch");
  endtask : t_branch
  task automatic t_cmp();
    for (int k = 0; k < 64; k++) tsfde_mem_i.mem[k] = 32'h0;
    restart(1'b1);
    repeat (4) @(negedge clk_i);
    a0 = pc_o;
    @(negedge clk_i);
    check(pc_o === a0 + TSFDE_STEP_CMP, "compressed step");
    check(size_o === TSFDE_SZ_HALF && addr_o === pc_o, "compressed fetch");
  endtask : t_cmp
  initial begin
    repeat (5) @(negedge clk_i);
    arst_n_i = 1'b1;
    t_walk();
    t_stall();
    t_data(32'he580_0000, 1'b1, TSFDE_SZ_WORD);
    t_data(32'he1c0_00b0, 1'b1, TSFDE_SZ_HALF);
    t_data(32'he5c0_0000, 1'b1, TSFDE_SZ_BYTE);
    t_data(32'he590_1000, 1'b0, TSFDE_SZ_WORD);
    t_branch();
    t_cmp();
    final_report();
  end
endmodule : three_stage_fetch_decode_execute_tb
